// file: src/chac_defs.svh
// Purpose: Offsets, field positions, reset values and codes of the command
//          and host-access control register bank.
// Assumes: Byte-wide registers on a seven-bit register address.
// Notes:   Definitions only; include by bare name.
`ifndef CHAC_DEFS_SVH
`define CHAC_DEFS_SVH

// Register offsets
`define CHAC_ADDR_CMD        7'h00
`define CHAC_ADDR_HAC        7'h01
`define CHAC_ADDR_VER        7'h7F

// Command register fields
`define CHAC_CMD_STANDBY_BIT 7
`define CHAC_CMD_RADIO_BIT   6
`define CHAC_CMD_CODE_MSB    4
`define CHAC_CMD_CODE_LSB    0

// Host-access control register fields
`define CHAC_HAC_UNLOCK_BIT  7
`define CHAC_HAC_HOST_BIT    6
`define CHAC_HAC_SAM_BIT     5
`define CHAC_HAC_LINK_MSB    3
`define CHAC_HAC_LINK_LSB    2

// Reset values
`define CHAC_CMD_CODE_RST    5'h00
`define CHAC_CMD_IDLE        5'h00
`define CHAC_LINK_RST        2'h0
`define CHAC_VERSION_RST     8'h5A

// Secure-module link select codes
`define CHAC_LINK_OFF        2'h0
`define CHAC_LINK_SPI        2'h1
`define CHAC_LINK_LS_TWI     2'h2
`define CHAC_LINK_TWI        2'h3

`endif

// file: src/chac_pkg.sv
// Purpose: Types shared by the register bank modules.
// Assumes: chac_defs.svh on the include path.
// Notes:   Nothing here holds state.
`include "chac_defs.svh"

package chac_pkg;

  // Secure-module link select encoding
  typedef enum logic [1:0]
  {
    CHAC_LINK_OFF_E    = `CHAC_LINK_OFF,
    CHAC_LINK_SPI_E    = `CHAC_LINK_SPI,
    CHAC_LINK_LS_TWI_E = `CHAC_LINK_LS_TWI,
    CHAC_LINK_TWI_E    = `CHAC_LINK_TWI
  } chac_link_t;

  // Decoded link enables, one bit per link kind
  typedef struct packed
  {
    logic two_wire;
    logic low_speed_two_wire;
    logic spi;
    logic off;
  } chac_link_dec_t;

  // Link select to one-hot enables
  function automatic chac_link_dec_t chac_link_decode(input chac_link_t sel);
    chac_link_dec_t d;
    d = '0;
    case (sel)
      CHAC_LINK_OFF_E:    d.off                = 1'b1;
      CHAC_LINK_SPI_E:    d.spi                = 1'b1;
      CHAC_LINK_LS_TWI_E: d.low_speed_two_wire = 1'b1;
      CHAC_LINK_TWI_E:    d.two_wire           = 1'b1;
      default:            d.off                = 1'b1;
    endcase
    return d;
  endfunction : chac_link_decode

endpackage : chac_pkg

// file: src/chac_hacl.sv
// Purpose: Host-access control register with one-shot write unlock.
// Assumes: Write strobes come from logic on mclk, one cycle per access.
// Notes:   Owner and link fields change only on an unlocked write.
`timescale 1ns/1ps
`include "chac_defs.svh"

module chac_hacl
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_b,
  // Write access from the register port
  input  wire logic               wr_any,
  input  wire logic               wr_hac,
  input  wire logic [7:0]         wdata,
  // Register state
  output logic                    write_unlock_flag,
  output logic                    owner_is_host,
  output logic                    owner_is_secure_module,
  output chac_pkg::chac_link_t    secure_module_link_select
);

  logic both_owners;

  // A request for both owners at once leaves the owner flags as they were; the link field still updates
  assign both_owners = wdata[`CHAC_HAC_HOST_BIT] & wdata[`CHAC_HAC_SAM_BIT];

  // One-shot unlock; any write after it consumes it
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      write_unlock_flag <= 1'b0;
    else if (wr_any && write_unlock_flag)
      write_unlock_flag <= 1'b0;
    else if (wr_hac && wdata[`CHAC_HAC_UNLOCK_BIT])
      write_unlock_flag <= 1'b1;
  end

  // Bus owner flags, changed only on the write after unlocking
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      owner_is_host          <= 1'b0;
      owner_is_secure_module <= 1'b0;
    end
    else if (wr_hac && write_unlock_flag && !both_owners)
    begin
      owner_is_host          <= wdata[`CHAC_HAC_HOST_BIT];
      owner_is_secure_module <= wdata[`CHAC_HAC_SAM_BIT];
    end
  end

  // Link select, also guarded so a stray write cannot drop the link
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      secure_module_link_select <= chac_pkg::chac_link_t'(`CHAC_LINK_RST);
    else if (wr_hac && write_unlock_flag)
      secure_module_link_select <= chac_pkg::chac_link_t'(
        wdata[`CHAC_HAC_LINK_MSB:`CHAC_HAC_LINK_LSB]);
  end

endmodule : chac_hacl

// file: src/chac_top.sv
// Purpose: Command register and host-access control register bank.
// Assumes: Register port driven by same-clock host interface logic.
//          All inputs are on mclk, so none passes a synchroniser.
// Notes:   Read data appears one cycle after the read strobe.
//          Reserved bits are not stored; they always read as zero.
//          The unlock flag is spent by any write, never by a read.
//          A host write outranks hardware updates in the same cycle.
//          Link enables trail the select field by one cycle.
`timescale 1ns/1ps
`include "chac_defs.svh"

// Ownership change, as seen from the host:
//   1. write host-access control with the unlock bit set
//   2. read back if wanted; reads leave the unlock armed
//   3. write host-access control with the wanted owner and link
// Any other write in between spends the unlock, and the owner
// write then lands as a locked write and changes nothing.
// Asking for both owners at once leaves the owners as they were.

module chac_top
#(
  parameter logic [7:0] VERSION_ID = `CHAC_VERSION_RST  // Arbitrary value
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [6:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  // Register port, answer
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // Command engine
  input  wire logic        cmd_done,
  input  wire logic        wake_event,
  // Command engine, outputs
  output logic      [4:0]  command_code,
  output logic             command_start,
  // Power control
  output logic             power_down,
  output logic             radio_power_down,
  // Bus ownership
  output logic             owner_is_host,
  output logic             owner_is_secure_module,
  // Secure-module link enables
  output logic             link_off,
  output logic             link_spi,
  output logic             link_low_speed_two_wire,
  output logic             link_two_wire
);

  // Per-register write strobes
  logic                    wr_cmd;
  logic                    wr_hac;

  // State seen from the host-access control register
  logic                    unlock;
  chac_pkg::chac_link_t    link_sel;
  chac_pkg::chac_link_dec_t link_dec;

  // Read data before the output flop
  logic [7:0]              next_rdata;

  // Address match, used by both the write and the read path
  // Full seven-bit compare, so no mapped register has an alias
  function automatic logic addr_is(input logic [6:0] a, input logic [6:0] ref_a);
    return a == ref_a;
  endfunction : addr_is

  // Write decode
  // Writes to the version or unmapped addresses match nothing here
  assign wr_cmd = reg_wr && addr_is(reg_addr, `CHAC_ADDR_CMD);
  assign wr_hac = reg_wr && addr_is(reg_addr, `CHAC_ADDR_HAC);

  // Host-access control register
  // Every write goes in as wr_any, since any write spends the unlock
  chac_hacl u_hacl
  (
    .mclk                      (mclk),
    .rst_b                     (rst_b),
    .wr_any                    (reg_wr),
    .wr_hac                    (wr_hac),
    .wdata                     (reg_wdata),
    .write_unlock_flag         (unlock),
    .owner_is_host             (owner_is_host),
    .owner_is_secure_module    (owner_is_secure_module),
    .secure_module_link_select (link_sel)
  );

  // Standby: host sets it, a wake event clears it; the host write wins
  // Held in a flop so it stays steady across host traffic
  // Wake acts only when no command-register write lands in the same cycle,
  // so a host that re-enters standby is never overruled
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      power_down <= 1'b0;
    else if (wr_cmd)
      power_down <= reg_wdata[`CHAC_CMD_STANDBY_BIT];
    else if (wake_event)
      power_down <= 1'b0;
  end

  // Modem power off is plain read/write
  // Not touched by the command engine, only by the host
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      radio_power_down <= 1'b0;
    else if (wr_cmd)
      radio_power_down <= reg_wdata[`CHAC_CMD_RADIO_BIT];
  end

  // Command code; a new host command outranks a finishing one,
  // so a command issued in the done cycle is not lost
  // The engine only ever returns the field to idle
  // Reads show the host code when both updates land in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      command_code <= `CHAC_CMD_CODE_RST;
    else if (wr_cmd)
      command_code <= reg_wdata[`CHAC_CMD_CODE_MSB:`CHAC_CMD_CODE_LSB];
    else if (cmd_done)
      command_code <= `CHAC_CMD_IDLE;
  end

  // Start pulse tells the command engine a code was written
  // Fires for every write, idle code included, so the engine
  // can also be told to stop by writing idle
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      command_start <= 1'b0;
    else
      command_start <= wr_cmd;
  end

  // Link enables, registered one cycle behind the select field
  // Decode stays one-hot, so exactly one enable is ever high
  // The extra flop costs a cycle but keeps each enable glitch free
  // Off is the reset state, so no link drives before software asks
  assign link_dec = chac_pkg::chac_link_decode(link_sel);

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      link_off                <= 1'b1;
      link_spi                <= 1'b0;
      link_low_speed_two_wire <= 1'b0;
      link_two_wire           <= 1'b0;
    end
    else
    begin
      link_off                <= link_dec.off;
      link_spi                <= link_dec.spi;
      link_low_speed_two_wire <= link_dec.low_speed_two_wire;
      link_two_wire           <= link_dec.two_wire;
    end
  end

  // Read mux; reserved bits and unmapped addresses read zero
  // Combinational image of the addressed register
  // Command bit 5 and host-access bits 4, 1 and 0 stay zero,
  // whatever software wrote into them
  always_comb
  begin
    next_rdata = 8'h00;
    if (addr_is(reg_addr, `CHAC_ADDR_CMD))
    begin
      next_rdata[`CHAC_CMD_STANDBY_BIT] = power_down;
      next_rdata[`CHAC_CMD_RADIO_BIT]   = radio_power_down;
      next_rdata[`CHAC_CMD_CODE_MSB:`CHAC_CMD_CODE_LSB] = command_code;
    end
    else if (addr_is(reg_addr, `CHAC_ADDR_HAC))
    begin
      next_rdata[`CHAC_HAC_UNLOCK_BIT] = unlock;
      next_rdata[`CHAC_HAC_HOST_BIT]   = owner_is_host;
      next_rdata[`CHAC_HAC_SAM_BIT]    = owner_is_secure_module;
      next_rdata[`CHAC_HAC_LINK_MSB:`CHAC_HAC_LINK_LSB] = link_sel;
    end
    else if (addr_is(reg_addr, `CHAC_ADDR_VER))
      next_rdata = VERSION_ID;
  end

  // Registered read answer; writes to the version address only spend an armed unlock
  // Data holds until the next read, so a slow host can pick it up
  // Valid is a single-cycle pulse for each read strobe
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

endmodule : chac_top

// file: sim/chac_top_chk.sv
// Purpose: Port checks for the command and host-access register bank.
// Assumes: Bound to chac_top; one clock domain.
// Notes:   Unlock state is shadowed here from write traffic.
`timescale 1ns/1ps
module chac_top_chk
#(
  parameter logic [7:0] VERSION_ID = 8'h5A
)
(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_b,
  // Register port
  input wire logic [6:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Engine and power
  input wire logic       cmd_done,
  input wire logic       wake_event,
  input wire logic       command_start,
  input wire logic [4:0] command_code,
  input wire logic       power_down,
  input wire logic       radio_power_down,
  // Ownership and link
  input wire logic       owner_is_host,
  input wire logic       owner_is_secure_module,
  input wire logic       link_off,
  input wire logic       link_spi,
  input wire logic       link_low_speed_two_wire,
  input wire logic       link_two_wire
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic unl;
  wire w0 = reg_wr && reg_addr == 7'h00;
  wire w1 = reg_wr && reg_addr == 7'h01;
  wire [1:0] own = {owner_is_host, owner_is_secure_module};
  wire [3:0] lnk = {link_two_wire, link_low_speed_two_wire, link_spi, link_off};
  // Shadow unlock; any write consumes it, so it cannot re-arm itself
  always_ff @(posedge mclk)
    if (!rst_b) unl <= 1'b0;
    else if (reg_wr) unl <= w1 && reg_wdata[7] && !unl;
  sequence s_open_wr;
    w1 && unl;
  endsequence
  a_owner_excl: assert property (own != 2'b11)
    else $error("both owners set");
  a_version_read: assert property (reg_rd && reg_addr == 7'h7F |=> reg_rdata == VERSION_ID)
    else $error("version read wrong");
  a_standby_set: assert property (w0 && reg_wdata[7] |=> power_down)
    else $error("standby not entered");
  a_radio_take: assert property (w0 |=> radio_power_down == $past(reg_wdata[6]))
    else $error("radio power wrong");
  a_code_take: assert property (w0 |=> command_code == $past(reg_wdata[4:0]))
    else $error("command code wrong");
  a_code_idle: assert property (cmd_done && !w0 |=> command_code == 5'h00)
    else $error("code not idle");
  a_owner_locked: assert property (!(w1 && unl) |=> $stable(own))
    else $error("owner changed locked");
  a_owner_set: assert property (s_open_wr ##0 reg_wdata[6:5] != 2'b11 |=> own == $past(reg_wdata[6:5]))
    else $error("owner not taken");
  a_owner_both: assert property (s_open_wr ##0 reg_wdata[6:5] == 2'b11 |=> $stable(own))
    else $error("double owner changed");
  a_link_decode: assert property (s_open_wr |-> ##2 lnk == 4'h1 << $past(reg_wdata[3:2], 2))
    else $error("link enables wrong");
  a_start_pulse: assert property (w0 |=> command_start)
    else $error("start pulse missing");
  a_start_quiet: assert property (!w0 |=> !command_start)
    else $error("stray start pulse");
  a_wake_clear: assert property (wake_event && !w0 |=> !power_down)
    else $error("standby not left");
endmodule : chac_top_chk

bind chac_top chac_top_chk #(.VERSION_ID(VERSION_ID)) u_chk
(
  .mclk                    (mclk),
  .rst_b                   (rst_b),
  .reg_addr                (reg_addr),
  .reg_wr                  (reg_wr),
  .reg_rd                  (reg_rd),
  .reg_wdata               (reg_wdata),
  .reg_rdata               (reg_rdata),
  .cmd_done                (cmd_done),
  .wake_event              (wake_event),
  .command_start           (command_start),
  .command_code            (command_code),
  .power_down              (power_down),
  .radio_power_down        (radio_power_down),
  .owner_is_host           (owner_is_host),
  .owner_is_secure_module  (owner_is_secure_module),
  .link_off                (link_off),
  .link_spi                (link_spi),
  .link_low_speed_two_wire (link_low_speed_two_wire),
  .link_two_wire           (link_two_wire)
);

// file: sim/chac_engine_model.sv
// Purpose: Command engine stand-in that ends the most recently started command.
// Assumes: Drives on the falling edge of mclk.
// Notes:   A slow end keeps a written code readable for a while.
`timescale 1ns/1ps
module chac_engine_model
#(
  parameter int DELAY = 12
)
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  // Engine handshake
  input  wire logic command_start,
  output logic      cmd_done
);
  int cnt = 0;
  // A later start supersedes the pending one
  always @(negedge mclk)
  begin
    cmd_done <= rst_b && cnt == 1;
    if (!rst_b) cnt <= 0;
    else if (command_start) cnt <= DELAY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule : chac_engine_model

// file: sim/command_and_host_access_control_tb.sv
// Purpose: Bench for the command and host-access register bank.
// Assumes: Inputs change on the falling edge of mclk.
// Notes:   Rows hold address, write data and expected readback.
`timescale 1ns/1ps
module command_and_host_access_control_tb;
  localparam logic [7:0] VER = 8'hC3;  // Arbitrary value
  logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, wake_event = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [4:0] command_code;
  logic reg_rvalid, cmd_done, command_start, power_down, link_off;
  int fails = 0, checks_done = 0;
  logic [23:0] rows [14] = '{
    {8'h00, 8'h45, 8'h45}, {8'h00, 8'h1F, 8'h1F}, {8'h01, 8'h44, 8'h00},
    {8'h01, 8'h80, 8'h80}, {8'h01, 8'h44, 8'h44}, {8'h01, 8'h80, 8'hC4},
    {8'h01, 8'h28, 8'h28}, {8'h01, 8'h80, 8'hA8}, {8'h01, 8'h6C, 8'h2C},
    {8'h01, 8'h80, 8'hAC}, {8'h01, 8'h0C, 8'h0C}, {8'h7F, 8'hFF, VER},
    {8'h05, 8'hFF, 8'h00}, {8'h00, 8'h00, 8'h00}};
  chac_top #(.VERSION_ID(VER)) u_chac_top (.mclk(mclk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cmd_done(cmd_done),
    .wake_event(wake_event), .command_code(command_code), .command_start(command_start),
    .power_down(power_down), .radio_power_down(), .owner_is_host(),
    .owner_is_secure_module(), .link_off(link_off), .link_spi(),
    .link_low_speed_two_wire(), .link_two_wire());
  chac_engine_model u_chac_engine_model (.mclk(mclk), .rst_b(rst_b),
    .command_start(command_start), .cmd_done(cmd_done));
  // 25 MHz clock
  always #20 mclk = ~mclk;
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, g);
      fails++;
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask : wr
  // Answer was registered at the edge that took the strobe
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, reg_rvalid});
    chk("rdata", e, reg_rdata);
  endtask : rd
  task automatic complete_run;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Watchdog well beyond the hundred or so cycles the tests need
  initial
  begin
    repeat (3000) @(posedge mclk);
    fails++;
    complete_run();
  end
  initial
  begin
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    rd(7'h00, 8'h00);
    rd(7'h01, 8'h00);
    chk("link_off", 8'h01, {7'h00, link_off});
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i][22:16], rows[i][15:8]);
      rd(rows[i][22:16], rows[i][7:0]);
    end
    $display("test rows done");
    wr(7'h00, 8'h81);
    @(negedge mclk);
    chk("power_down", 8'h01, {7'h00, power_down});
    for (int k = 0; k < 30 && command_code !== 5'h00; k++)
      @(negedge mclk);
    chk("code_idle", 8'h00, {3'h0, command_code});
    wake_event = 1'b1;
    @(negedge mclk);
    wake_event = 1'b0;
    @(negedge mclk);
    chk("wake", 8'h00, {7'h00, power_down});
    $display("test standby done");
    wr(7'h01, 8'h80);
    wr(7'h00, 8'h00);
    wr(7'h01, 8'h40);
    rd(7'h01, 8'h0C);
    $display("test unlock done");
    wr(7'h00, 8'h80);
    chk("power_pre", 8'h01, {7'h00, power_down});
    chk("link_pre", 8'h00, {7'h00, link_off});
    rst_b = 1'b0;
    repeat (5) @(negedge mclk);
    rst_b = 1'b1;
    rd(7'h00, 8'h00);
    rd(7'h01, 8'h00);
    chk("link_off", 8'h01, {7'h00, link_off});
    chk("power_down", 8'h00, {7'h00, power_down});
    $display("test mid reset done");
    complete_run();
  end
endmodule : command_and_host_access_control_tb
